// ### fmb_consts.svh
// Purpose: constants for the flash/modem local bus strobe block
// Assumes: core clock of 250 MHz, local bus data 8 bits wide
// Notes:   times in ns, cycle counts derived from them
`ifndef FMB_CONSTS_SVH
`define FMB_CONSTS_SVH

`define FMB_ADDR_W        17
`define FMB_MODEM_ADDR_W  7
`define FMB_DATA_W        8
`define FMB_BOOT_EN_RST   1'b1

`define FMB_CLK_PERIOD_NS 4
`define FMB_SETUP_NS      20
`define FMB_STROBE_NS     120
`define FMB_HOLD_NS       20
`define FMB_CCLK_HALF_NS  20

`define FMB_NS2CYC(ns) \
  (((ns) + `FMB_CLK_PERIOD_NS - 1) / `FMB_CLK_PERIOD_NS)
`define FMB_SETUP_CYC     `FMB_NS2CYC(`FMB_SETUP_NS)
`define FMB_STROBE_CYC    `FMB_NS2CYC(`FMB_STROBE_NS)
`define FMB_HOLD_CYC      `FMB_NS2CYC(`FMB_HOLD_NS)
`define FMB_CCLK_HALF_CYC `FMB_NS2CYC(`FMB_CCLK_HALF_NS)
`define FMB_CNT_W         8

`endif

// ### fmb_pkg.sv
// Purpose: types shared by the local bus strobe block
// Assumes: widths from fmb_consts.svh
// Notes:   none
`include "fmb_consts.svh"
package fmb_pkg;
  typedef logic [`FMB_ADDR_W-1:0] fmb_addr_t;
  typedef logic [`FMB_DATA_W-1:0] fmb_data_t;
  typedef logic [`FMB_CNT_W-1:0]  fmb_cnt_t;
  typedef enum logic [1:0]
  {
    FMB_IDLE   = 2'b00,
    FMB_SETUP  = 2'b01,
    FMB_STROBE = 2'b10,
    FMB_HOLD   = 2'b11
  } fmb_state_e;
endpackage

// ### fmb_cclk_if.sv
// Purpose: carries the companion clock between divider and top
// Assumes: one clock domain
// Notes:   level signal, registered in the divider
`timescale 1ns/10ps
interface fmb_cclk_if;
  logic cclk;
  modport gen (output cclk);
  modport use_side (input cclk);
endinterface

// ### fmb_cclk_div.sv
// Purpose: free-running companion clock divider
// Assumes: half period from fmb_consts.svh
// Notes:   runs from reset release, independent of accesses
`timescale 1ns/10ps
`include "fmb_consts.svh"
module fmb_cclk_div
  import fmb_pkg::*;
(
  input  wire logic   i_sys_clk,
  input  wire logic   i_rst,
  fmb_cclk_if.gen     cclk_if
);
  fmb_cnt_t cnt_reg;
  fmb_cnt_t cnt_next;
  logic     clk_reg;
  logic     clk_next;

  always_comb
  begin
    cnt_next = cnt_reg + 8'h01;
    clk_next = clk_reg;
    if (cnt_reg == fmb_cnt_t'(`FMB_CCLK_HALF_CYC - 1))
    begin
      cnt_next = 8'h00;
      clk_next = ~clk_reg;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_reg <= 8'h00;
      clk_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      clk_reg <= clk_next;
    end
  end

  assign cclk_if.cclk = clk_reg;
endmodule

// ### fmb_local_bus.sv
// Purpose: strobe, select and address logic of the local bus
// Assumes: i_rst is the host bus reset; requests from core logic
// Notes:   one access at a time; address mapping is latched per access, select follows the boot bit directly
`timescale 1ns/10ps
`include "fmb_consts.svh"
module fmb_local_bus
  import fmb_pkg::*;
(
  input  wire logic            i_sys_clk,
  input  wire logic            i_rst,
  // access requests from core logic
  input  wire logic            i_req_valid,
  input  wire logic            i_req_write,
  input  wire fmb_pkg::fmb_addr_t i_req_addr,
  input  wire fmb_pkg::fmb_data_t i_req_wdata,
  output logic                 o_req_ready,
  output fmb_pkg::fmb_data_t   o_rd_data,
  output logic                 o_rd_valid,
  output logic                 o_done,
  // boot enable control bit
  input  wire logic            i_boot_en_wr,
  input  wire logic            i_boot_en_val,
  output logic                 o_boot_en,
  // local bus pins
  output logic                 o_local_read_strobe_n,
  output logic                 o_local_write_strobe_n,
  output logic                 o_flash_cs_n,
  output logic                 o_flash_modem_select,
  output logic                 o_companion_clock_out,
  output fmb_pkg::fmb_addr_t   o_local_addr,
  input  wire fmb_pkg::fmb_data_t i_local_data,
  output fmb_pkg::fmb_data_t   o_local_data,
  output logic                 o_local_data_oe
);
  import fmb_pkg::*;

  function automatic fmb_addr_t map_addr(input fmb_addr_t a,
                                         input logic flash);
    fmb_addr_t m;
    m = a;
    if (!flash)
    begin
      m = '0;
      m[`FMB_MODEM_ADDR_W-1:0] = a[`FMB_MODEM_ADDR_W-1:0];
    end
    return m;
  endfunction

  // boot enable bit
  logic boot_en_reg;
  logic boot_en_next;

  always_comb
  begin
    boot_en_next = boot_en_reg;
    if (i_boot_en_wr)
    begin
      boot_en_next = i_boot_en_val;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      boot_en_reg <= `FMB_BOOT_EN_RST;
    end
    else
    begin
      boot_en_reg <= boot_en_next;
    end
  end

  // data pin synchroniser
  fmb_data_t din_meta_reg;
  fmb_data_t din_sync_reg;

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      din_meta_reg <= 8'h00;
      din_sync_reg <= 8'h00;
    end
    else
    begin
      din_meta_reg <= i_local_data;
      din_sync_reg <= din_meta_reg;
    end
  end

  // access sequencer
  fmb_state_e state_reg;
  fmb_state_e state_next;
  fmb_cnt_t   cnt_reg;
  fmb_cnt_t   cnt_next;
  logic       wr_reg;
  logic       wr_next;
  fmb_addr_t  addr_reg;
  fmb_addr_t  addr_next;
  fmb_data_t  wdata_reg;
  fmb_data_t  wdata_next;
  fmb_data_t  rdata_reg;
  fmb_data_t  rdata_next;
  logic       rvalid_reg;
  logic       rvalid_next;
  logic       done_reg;
  logic       done_next;
  logic       ready_reg;
  logic       ready_next;
  logic       oe_n_reg;
  logic       oe_n_next;
  logic       we_n_reg;
  logic       we_n_next;
  logic       cs_n_reg;
  logic       cs_n_next;
  logic       doe_reg;
  logic       doe_next;

  always_comb
  begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    wr_next     = wr_reg;
    addr_next   = addr_reg;
    wdata_next  = wdata_reg;
    rdata_next  = rdata_reg;
    rvalid_next = 1'b0;
    done_next   = 1'b0;
    ready_next  = 1'b0;
    oe_n_next   = 1'b1;
    we_n_next   = 1'b1;
    cs_n_next   = 1'b1;
    doe_next    = 1'b0;
    case (state_reg)
      FMB_IDLE:
      begin
        ready_next = 1'b1;
        if (i_req_valid && ready_reg)
        begin
          wr_next    = i_req_write;
          addr_next  = map_addr(i_req_addr, boot_en_reg);
          wdata_next = i_req_wdata;
          cnt_next   = fmb_cnt_t'(`FMB_SETUP_CYC - 1);
          state_next = FMB_SETUP;
          ready_next = 1'b0;
          cs_n_next  = 1'b0;
          doe_next   = i_req_write;
        end
      end
      FMB_SETUP:
      begin
        cs_n_next = 1'b0;
        doe_next  = wr_reg;
        if (cnt_reg == 8'h00)
        begin
          cnt_next   = fmb_cnt_t'(`FMB_STROBE_CYC - 1);
          state_next = FMB_STROBE;
          oe_n_next  = wr_reg;
          we_n_next  = ~wr_reg;
        end
        else
        begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      FMB_STROBE:
      begin
        cs_n_next = 1'b0;
        doe_next  = wr_reg;
        if (cnt_reg == 8'h00)
        begin
          // data has passed the synchroniser by now
          if (!wr_reg)
          begin
            rdata_next  = din_sync_reg;
            rvalid_next = 1'b1;
          end
          cnt_next   = fmb_cnt_t'(`FMB_HOLD_CYC - 1);
          state_next = FMB_HOLD;
        end
        else
        begin
          cnt_next  = cnt_reg - 8'h01;
          oe_n_next = wr_reg;
          we_n_next = ~wr_reg;
        end
      end
      FMB_HOLD:
      begin
        doe_next = wr_reg;
        if (cnt_reg == 8'h00)
        begin
          state_next = FMB_IDLE;
          done_next  = 1'b1;
          doe_next   = 1'b0;
          ready_next = 1'b1;
        end
        else
        begin
          cnt_next  = cnt_reg - 8'h01;
          cs_n_next = 1'b0;
        end
      end
      default:
      begin
        state_next = FMB_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg  <= FMB_IDLE;
      cnt_reg    <= 8'h00;
      wr_reg     <= 1'b0;
      addr_reg   <= '0;
      wdata_reg  <= 8'h00;
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
      done_reg   <= 1'b0;
      ready_reg  <= 1'b0;
      oe_n_reg   <= 1'b1;
      we_n_reg   <= 1'b1;
      cs_n_reg   <= 1'b1;
      doe_reg    <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      wr_reg     <= wr_next;
      addr_reg   <= addr_next;
      wdata_reg  <= wdata_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      done_reg   <= done_next;
      ready_reg  <= ready_next;
      oe_n_reg   <= oe_n_next;
      we_n_reg   <= we_n_next;
      cs_n_reg   <= cs_n_next;
      doe_reg    <= doe_next;
    end
  end

  // companion clock
  fmb_cclk_if cclk_if ();

  fmb_cclk_div u_cclk_div
  (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .cclk_if   (cclk_if.gen)
  );

  assign o_companion_clock_out  = cclk_if.cclk;
  assign o_local_read_strobe_n  = oe_n_reg;
  assign o_local_write_strobe_n = we_n_reg;
  assign o_flash_cs_n           = cs_n_reg;
  assign o_flash_modem_select   = boot_en_reg;
  assign o_boot_en              = boot_en_reg;
  assign o_local_addr           = addr_reg;
  assign o_local_data           = wdata_reg;
  assign o_local_data_oe        = doe_reg;
  assign o_rd_data              = rdata_reg;
  assign o_rd_valid             = rvalid_reg;
  assign o_done                 = done_reg;
  assign o_req_ready            = ready_reg;
endmodule

// ### fmb_chk_asserts.sv
// Purpose: port checks of the local bus strobe block
// Assumes: single clock, async high reset
// Notes:   bound to fmb_local_bus below
`timescale 1ns/10ps
module fmb_chk
  import fmb_pkg::*;
(
  input wire logic               i_sys_clk,
  input wire logic               i_rst,
  input wire logic               i_boot_en_wr,
  input wire logic               i_boot_en_val,
  input wire logic               o_boot_en,
  input wire logic               o_req_ready,
  input wire logic               o_rd_valid,
  input wire logic               o_local_read_strobe_n,
  input wire logic               o_local_write_strobe_n,
  input wire logic               o_flash_cs_n,
  input wire logic               o_flash_modem_select,
  input wire logic               o_companion_clock_out,
  input wire fmb_pkg::fmb_addr_t o_local_addr,
  input wire logic               o_local_data_oe
);
  wire rd_n = o_local_read_strobe_n;
  wire wr_n = o_local_write_strobe_n;
  wire ck   = o_companion_clock_out;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  property p_excl; rd_n || wr_n; endproperty
  a_excl: assert property (p_excl) else $error("both strobes low");
  property p_idle; o_req_ready |-> rd_n && wr_n && o_flash_cs_n; endproperty
  a_idle: assert property (p_idle) else $error("strobe while idle");
  property p_sel; o_flash_modem_select == o_boot_en; endproperty
  a_sel: assert property (p_sel) else $error("select not boot bit");
  property p_bw; i_boot_en_wr |=> o_boot_en == $past(i_boot_en_val);
  endproperty
  a_bw: assert property (p_bw) else $error("boot bit not written");
  property p_cs; !(rd_n && wr_n) |-> !o_flash_cs_n; endproperty
  a_cs: assert property (p_cs) else $error("strobe without select");
  property p_ck; $rose(ck) |=> $stable(ck)[*4] ##1 $fell(ck); endproperty
  a_ck: assert property (p_ck) else $error("companion clock period");
  property p_ma;
    $fell(o_flash_cs_n) && !o_flash_modem_select |-> o_local_addr[16:7] == 0;
  endproperty
  a_ma: assert property (p_ma) else $error("modem address high");
  property p_rv; o_rd_valid |-> $rose(rd_n); endproperty
  a_rv: assert property (p_rv) else $error("read data off strobe");
  property p_oe; o_local_data_oe |-> !o_flash_cs_n && rd_n; endproperty
  a_oe: assert property (p_oe) else $error("data driven on read");
  c_rd: cover property (!rd_n && o_flash_modem_select);
  c_mw: cover property (!wr_n && !o_flash_modem_select);
  c_bw: cover property (i_boot_en_wr && !i_boot_en_val);
endmodule
bind fmb_local_bus fmb_chk u_chk (.*);

// ### fmb_mem.sv
// Purpose: flash memory and modem model on the local bus
// Assumes: strobes active low, select high means flash
// Notes:   released data pins show the inverse of the last value
`timescale 1ns/10ps
module fmb_mem
  import fmb_pkg::*;
(
  input  wire logic               i_rd_n,
  input  wire logic               i_wr_n,
  input  wire logic               i_cs_n,
  input  wire logic               i_sel,
  input  wire fmb_pkg::fmb_addr_t i_addr,
  input  wire fmb_pkg::fmb_data_t i_data,
  output fmb_pkg::fmb_data_t      o_data
);
  fmb_data_t fmem [0:131071];
  fmb_data_t mmem [0:127];
  fmb_data_t last = 8'h00;
  // writes land on the rising write strobe
  always @(posedge i_wr_n)
    if (!i_cs_n && i_sel)
      fmem[i_addr] = i_data;
    else if (!i_cs_n)
      mmem[i_addr[6:0]] = i_data;
  always @*
  begin
    if (!i_cs_n && !i_rd_n)
      last = i_sel ? fmem[i_addr] : mmem[i_addr[6:0]];
    o_data = (!i_cs_n && !i_rd_n) ? last : ~last;
  end
endmodule

// ### flash_modem_local_bus_strobes_tb.sv
// Purpose: self-checking bench of the local bus strobe block
// Assumes: inputs change 1 ns after the rising edge
// Notes:   flash and modem traffic through the memory model
`timescale 1ns/10ps
`include "fmb_consts.svh"
`define CHK(n, e, a) \
  begin checked++; if ((a) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module flash_modem_local_bus_strobes_tb;
  import fmb_pkg::*;
  logic      clk = 1'b0;
  logic      rst = 1'b1;
  logic      vld = 1'b0;
  logic      wr  = 1'b0;
  logic      bw  = 1'b0;
  logic      bv  = 1'b0;
  fmb_addr_t adr = '0;
  fmb_addr_t la;
  fmb_addr_t sa;
  fmb_data_t wd  = '0;
  fmb_data_t rdd;
  fmb_data_t ld;
  fmb_data_t lo;
  logic      rdy, rv, dn, be, rn, wn, cs, sel, ck, oe;
  int        fail_count = 0;
  int        checked = 0;
  fmb_local_bus uut (.i_sys_clk(clk), .i_rst(rst), .i_req_valid(vld),
    .i_req_write(wr), .i_req_addr(adr), .i_req_wdata(wd),
    .o_req_ready(rdy), .o_rd_data(rdd), .o_rd_valid(rv), .o_done(dn),
    .i_boot_en_wr(bw), .i_boot_en_val(bv), .o_boot_en(be),
    .o_local_read_strobe_n(rn), .o_local_write_strobe_n(wn),
    .o_flash_cs_n(cs), .o_flash_modem_select(sel),
    .o_companion_clock_out(ck), .o_local_addr(la), .i_local_data(ld),
    .o_local_data(lo), .o_local_data_oe(oe));
  fmb_mem mem (.i_rd_n(rn), .i_wr_n(wn), .i_cs_n(cs), .i_sel(sel),
    .i_addr(la), .i_data(lo), .o_data(ld));
  initial
    forever #2 clk = ~clk;
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one access; strobe counts tell which strobe moved
  task automatic acc(input logic w, input fmb_addr_t a, input fmb_data_t d);
    int n, rs, ws, cl, ol, vl, tot;
    tot = `FMB_SETUP_CYC + `FMB_STROBE_CYC + `FMB_HOLD_CYC;
    for (n = 0; n < 50 && rdy !== 1'b1; n++)
      step();
    vld = 1'b1;
    wr = w;
    adr = a;
    wd = d;
    step();
    vld = 1'b0;
    rs = 0;
    ws = 0;
    cl = 0;
    ol = 0;
    vl = 0;
    for (n = 0; n < 60 && dn !== 1'b1; n++)
    begin
      if (cs === 1'b0)
        sa = la;
      rs += (rn === 1'b0);
      ws += (wn === 1'b0);
      cl += (cs === 1'b0);
      ol += (oe === 1'b1);
      vl += (rv === 1'b1);
      step();
    end
    `CHK("done", 1'b1, dn)
    `CHK("span", tot, n)
    `CHK("csspan", tot, cl)
    `CHK("strobe", `FMB_STROBE_CYC, w ? ws : rs)
    `CHK("other", 0, w ? rs : ws)
    `CHK("drive", w ? tot : 0, ol)
    `CHK("rvalid", w ? 0 : 1, vl)
    `CHK("ready", 1'b1, rdy)
  endtask
  task automatic boot(input logic v);
    bw = 1'b1;
    bv = v;
    step();
    bw = 1'b0;
    `CHK("select", v, sel)
  endtask
  task automatic t_reset();
    `CHK("boot", 1'b1, be)
    `CHK("rdy0", 1'b0, rdy)
    `CHK("idle", 2'b11, {rn, wn})
    `CHK("cs", 1'b1, cs)
  endtask
  task automatic t_flash();
    acc(1'b1, 17'h1abcd, 8'ha5);
    `CHK("faddr", 17'h1abcd, sa)
    acc(1'b0, 17'h1abcd, 8'h00);
    `CHK("fread", 8'ha5, rdd)
  endtask
  task automatic t_modem();
    boot(1'b0);
    acc(1'b1, 17'h1ff85, 8'h3c);
    `CHK("maddr", 17'h00005, sa)
    acc(1'b0, 17'h00085, 8'h00);
    `CHK("mread", 8'h3c, rdd)
    `CHK("select", 1'b0, sel)
  endtask
  task automatic t_back();
    boot(1'b1);
    acc(1'b0, 17'h1abcd, 8'h00);
    `CHK("back", 8'ha5, rdd)
  endtask
  task automatic t_rst();
    boot(1'b0);
    vld = 1'b1;
    step();
    vld = 1'b0;
    repeat (10) step();
    rst = 1'b1;
    step();
    rst = 1'b0;
    `CHK("rboot", 1'b1, sel)
    `CHK("ridle", 2'b11, {rn, wn})
    `CHK("rrdy0", 1'b0, rdy)
    step();
    `CHK("rrdy", 1'b1, rdy)
    `CHK("rcs", 1'b1, cs)
  endtask
  task automatic t_clk();
    int n;
    logic p;
    n = 0;
    repeat (100)
    begin
      p = ck;
      step();
      n += (ck !== p);
    end
    `CHK("toggles", 100 / `FMB_CCLK_HALF_CYC, n)
  endtask
  initial
  begin
    #20000;
    fail_count++;
    complete_run();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    step();
    t_flash();
    t_modem();
    t_back();
    t_rst();
    t_clk();
    complete_run();
  end
endmodule
